// >>> rtl/auxcv_defines.svh
// Purpose: Register indices, field positions and reset values of the
//          auxiliary converter control block.
// Assumes: Byte address on the bus is four times the register index.
// Notes:   Definitions only.
`ifndef AUXCV_DEFINES_SVH
`define AUXCV_DEFINES_SVH

// ==========================================
// Register indices
`define AUXCV_IDX_REFCFG 8'h17
`define AUXCV_IDX_AVG_A 8'h18
`define AUXCV_IDX_AVG_B 8'h19
`define AUXCV_IDX_RES_A1_HI 8'h1A
`define AUXCV_IDX_RES_A1_LO 8'h1B
`define AUXCV_IDX_RES_A2_HI 8'h1C
`define AUXCV_IDX_RES_A2_LO 8'h1D
`define AUXCV_IDX_RES_B_HI 8'h1E
`define AUXCV_IDX_RES_B_LO 8'h1F
`define AUXCV_IDX_RES_RSV_HI 8'h20
`define AUXCV_IDX_RES_RSV_LO 8'h21
`define AUXCV_IDX_CTRL 8'h22
`define AUXCV_IDX_CLKDIV 8'h23

// ==========================================
// Control register fields
`define AUXCV_CTRL_PORT_EN 7
`define AUXCV_CTRL_PORT_CHOICE 6
`define AUXCV_CTRL_REFSEL_B 5
`define AUXCV_CTRL_START_B 3
`define AUXCV_CTRL_REFSEL_A 2
`define AUXCV_CTRL_INSEL_A 1
`define AUXCV_CTRL_START_A 0

// ==========================================
// Other fields
`define AUXCV_REF_INT_EN 1
`define AUXCV_REF_SCALE 0
`define AUXCV_AVG_GO 7
`define AUXCV_AVG_CODE_HI 2
`define AUXCV_AVG_CODE_MAX 3'h6
`define AUXCV_CTRL_RST 8'h00
`define AUXCV_CLKDIV_RST 2'h0
`define AUXCV_AVG_RST 3'h0
`define AUXCV_ADDR_LSB 2

`endif

// >>> rtl/auxcv_pkg.sv
// Purpose: Types shared by the auxiliary converter control files.
// Assumes: Nothing beyond the defines header.
// Notes:   Enumerations only.
`default_nettype none
package auxcv_pkg;
  // Converter sequencer states
  typedef enum logic [1:0] {AUXCV_IDLE, AUXCV_REQ, AUXCV_WAIT} auxcv_state_e;
  // Conversion clock source codes
  typedef enum logic [1:0] {
    AUXCV_DIV4, AUXCV_DIV2, AUXCV_DIV1, AUXCV_SERCLK
  } auxcv_clkdiv_e;
endpackage
`default_nettype wire

// >>> rtl/auxcv_channel.sv
// Purpose: One converter sequencer: single or averaged conversions.
// Assumes: Converter answers each sample request with a done pulse.
// Notes:   Starts while busy are dropped.
`include "auxcv_defines.svh"
`default_nettype none
module auxcv_channel (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic convTick,
  input wire logic start,
  input wire logic avgStart,
  input wire logic [2:0] avgCode,
  input wire logic sampleDone,
  input wire logic [9:0] sampleData,
  output logic sampleReq,
  output logic busy,
  output logic resultValid,
  output logic [9:0] result
);
  import auxcv_pkg::*;

  auxcv_state_e state_r;
  logic [2:0] shift_r;
  logic [6:0] count_r;
  logic [15:0] sum_r;
  logic [15:0] sumNxt;
  logic lastSample;

  // Code seven is unused; it falls back to one sample
  function automatic logic [2:0] legalCode(input logic [2:0] code);
    legalCode = (code > `AUXCV_AVG_CODE_MAX) ? 3'h0 : code;
  endfunction

  assign busy = (state_r != AUXCV_IDLE);
  assign sumNxt = sum_r + {6'h00, sampleData};
  assign lastSample = (count_r == 7'((7'h01 << shift_r) - 7'h01));

  // Sequencer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= AUXCV_IDLE;
      shift_r <= 3'h0;
      count_r <= 7'h00;
      sum_r <= 16'h0000;
    end else begin
      unique case (state_r)
        AUXCV_IDLE: begin
          if (start || avgStart) begin
            shift_r <= avgStart ? legalCode(avgCode) : 3'h0;
            count_r <= 7'h00;
            sum_r <= 16'h0000;
            state_r <= AUXCV_REQ;
          end
        end
        AUXCV_REQ: begin
          if (convTick) begin
            state_r <= AUXCV_WAIT;
          end
        end
        AUXCV_WAIT: begin
          if (sampleDone) begin
            sum_r <= sumNxt;
            count_r <= count_r + 7'h01;
            state_r <= lastSample ? AUXCV_IDLE : AUXCV_REQ;
          end
        end
      endcase
    end
  end

  // Sample request on the conversion clock enable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sampleReq <= 1'b0;
    end else begin
      sampleReq <= (state_r == AUXCV_REQ) && convTick;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      result <= 10'h000;
      resultValid <= 1'b0;
    end else begin
      resultValid <= 1'b0;
      if ((state_r == AUXCV_WAIT) && sampleDone && lastSample) begin
        result <= 10'(sumNxt >> shift_r);
        resultValid <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/aux_converter_control.sv
// Purpose: Control, clocking and result holding for two auxiliary converters.
// Assumes: Avalon-MM byte addressing; converter done pulses are synchronous.
// Notes:   Each register is one aligned word at four times its index.
//
// How it works
// - Results are read-only 10-bit offset binary, always the latest conversion.
// - Each result splits into an upper-eight and a lower-two byte.
// - Two converters; only A has a two-way input multiplexer.
// - Control bit 7 enables the side serial port for start; readback ignores it.
// - Control bit 6 picks converter B for the side port; low picks A.
// - Bits 5 and 2 pick internal reference for B and A; low external.
// - Control bit 1 high connects the first input pin to A, low the second.
// - Bits 3 and 0 start B and A; they always read zero.
// - Start-average runs the programmed sample count, then stores the mean.
// - With internal reference enabled, scale bit picks 3.0 V or 2.5 V.
// - Clock code picks receive clock over 4, 2, 1, or serial clock.
`include "auxcv_defines.svh"
`default_nettype none
module aux_converter_control (
  input wire logic core_clk,
  input wire logic arst_n,
  // Avalon-MM slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Clock sources for the converters
  input wire logic rxClkTick,
  input wire logic serClkTick,
  output logic convTick,
  // Side serial port
  input wire logic sidePortStart,
  output logic sidePortEn,
  output logic sidePortChoice,
  output logic [9:0] sidePortResult,
  // Reference and multiplexer controls
  output logic refSelA,
  output logic refSelB,
  output logic refIntEn,
  output logic refScale2v5,
  output logic inSelFirstPin,
  // Converter A
  output logic sampleReqA,
  input wire logic sampleDoneA,
  input wire logic [9:0] sampleDataA,
  output logic busyA,
  // Converter B
  output logic sampleReqB,
  input wire logic sampleDoneB,
  input wire logic [9:0] sampleDataB,
  output logic busyB
);
  import auxcv_pkg::*;

  // ==========================================
  // Reset release
  logic rstMeta_r;
  logic rst_n;

  // Asynchronous assert, two-flop release
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rst_n <= rstMeta_r;
    end
  end

  // ==========================================
  // Bus decode
  logic [7:0] regIdx;
  logic alignedOk;
  logic ack_r;
  logic wrStb;
  logic rdStb;

  // Register index compare, used by the write and start decode paths
  function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
    hit = (idx == want);
  endfunction

  assign regIdx = avs_address[9:`AUXCV_ADDR_LSB];
  assign alignedOk = (avs_address[`AUXCV_ADDR_LSB-1:0] == 2'h0);
  // One wait state: the answer lands at the second edge of a request
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  // Writes commit only at the answer edge, where waitrequest is low
  assign wrStb = avs_write && ack_r && alignedOk && avs_byteenable[0];
  assign rdStb = avs_read && !ack_r;

  // Acknowledge flop
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
    end
  end

  // ==========================================
  // Software registers
  logic [7:0] ctrl_r;
  logic [1:0] refCfg_r;
  logic [2:0] avgCodeA_r;
  logic [2:0] avgCodeB_r;
  auxcv_clkdiv_e clkDiv_r;
  logic [7:0] wb;

  assign wb = avs_writedata[7:0];

  // Control register; start bits are not stored
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `AUXCV_CTRL_RST;
    end else if (wrStb && hit(regIdx, `AUXCV_IDX_CTRL)) begin
      ctrl_r <= wb & ~((8'h01 << `AUXCV_CTRL_START_B) | (8'h01 << `AUXCV_CTRL_START_A));
    end
  end

  // Reference configuration
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      refCfg_r <= 2'h0;
    end else if (wrStb && hit(regIdx, `AUXCV_IDX_REFCFG)) begin
      refCfg_r <= wb[`AUXCV_REF_INT_EN:`AUXCV_REF_SCALE];
    end
  end

  // Sample counts per converter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avgCodeA_r <= `AUXCV_AVG_RST;
      avgCodeB_r <= `AUXCV_AVG_RST;
    end else if (wrStb) begin
      if (hit(regIdx, `AUXCV_IDX_AVG_A)) begin
        avgCodeA_r <= wb[`AUXCV_AVG_CODE_HI:0];
      end
      if (hit(regIdx, `AUXCV_IDX_AVG_B)) begin
        avgCodeB_r <= wb[`AUXCV_AVG_CODE_HI:0];
      end
    end
  end

  // Conversion clock choice
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkDiv_r <= auxcv_clkdiv_e'(`AUXCV_CLKDIV_RST);
    end else if (wrStb && hit(regIdx, `AUXCV_IDX_CLKDIV)) begin
      clkDiv_r <= auxcv_clkdiv_e'(wb[1:0]);
    end
  end

  // ==========================================
  // Static controls
  // Side port enable
  assign sidePortEn = ctrl_r[`AUXCV_CTRL_PORT_EN];
  assign sidePortChoice = ctrl_r[`AUXCV_CTRL_PORT_CHOICE];
  assign refSelB = ctrl_r[`AUXCV_CTRL_REFSEL_B];
  assign refSelA = ctrl_r[`AUXCV_CTRL_REFSEL_A];
  assign refIntEn = refCfg_r[`AUXCV_REF_INT_EN];
  assign refScale2v5 = refCfg_r[`AUXCV_REF_SCALE];
  assign inSelFirstPin = ctrl_r[`AUXCV_CTRL_INSEL_A];

  // ==========================================
  // Conversion clock divider
  logic [1:0] divCnt_r;
  logic convTickNxt;

  always_comb begin
    unique case (clkDiv_r)
      AUXCV_DIV4: convTickNxt = rxClkTick && (divCnt_r == 2'h3);
      AUXCV_DIV2: convTickNxt = rxClkTick && divCnt_r[0];
      AUXCV_DIV1: convTickNxt = rxClkTick;
      AUXCV_SERCLK: convTickNxt = serClkTick;
    endcase
  end

  // Divider counts receive clock enables
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_r <= 2'h0;
      convTick <= 1'b0;
    end else begin
      if (rxClkTick) begin
        divCnt_r <= divCnt_r + 2'h1;
      end
      convTick <= convTickNxt;
    end
  end

  // ==========================================
  // Start requests
  logic swStartA;
  logic swStartB;
  logic portStartA;
  logic portStartB;
  logic avgGoA;
  logic avgGoB;
  logic [1:0] chStart;
  logic [1:0] chAvg;
  logic [1:0] chDone;
  logic [1:0] chReq;
  logic [1:0] chBusy;
  logic [1:0] chValid;
  logic [9:0] chData [2];
  logic [9:0] chResult [2];
  logic [2:0] chCode [2];

  // One-shot starts from a control write
  assign swStartA = wrStb && hit(regIdx, `AUXCV_IDX_CTRL) && wb[`AUXCV_CTRL_START_A];
  assign swStartB = wrStb && hit(regIdx, `AUXCV_IDX_CTRL) && wb[`AUXCV_CTRL_START_B];
  // Side port starts only while enabled
  assign portStartA = sidePortStart && sidePortEn && !sidePortChoice;
  assign portStartB = sidePortStart && sidePortEn && sidePortChoice;
  assign avgGoA = wrStb && hit(regIdx, `AUXCV_IDX_AVG_A) && wb[`AUXCV_AVG_GO];
  assign avgGoB = wrStb && hit(regIdx, `AUXCV_IDX_AVG_B) && wb[`AUXCV_AVG_GO];

  assign chStart = {swStartB || portStartB, swStartA || portStartA};
  assign chAvg = {avgGoB, avgGoA};
  assign chDone = {sampleDoneB, sampleDoneA};
  assign chData[0] = sampleDataA;
  assign chData[1] = sampleDataB;
  // New count applies to the same write that starts averaging
  assign chCode[0] = avgGoA ? wb[`AUXCV_AVG_CODE_HI:0] : avgCodeA_r;
  assign chCode[1] = avgGoB ? wb[`AUXCV_AVG_CODE_HI:0] : avgCodeB_r;
  assign sampleReqA = chReq[0];
  assign sampleReqB = chReq[1];
  assign busyA = chBusy[0];
  assign busyB = chBusy[1];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : gChan
      auxcv_channel uChan (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .convTick(convTick),
        .start(chStart[gi]),
        .avgStart(chAvg[gi]),
        .avgCode(chCode[gi]),
        .sampleDone(chDone[gi]),
        .sampleData(chData[gi]),
        .sampleReq(chReq[gi]),
        .busy(chBusy[gi]),
        .resultValid(chValid[gi]),
        .result(chResult[gi])
      );
    end
  endgenerate

  // ==========================================
  // Result holding
  logic pinFirst_r;
  logic [9:0] resA1_r;
  logic [9:0] resA2_r;
  logic [9:0] resB_r;
  logic inSelNow;

  // Start written with the pin choice uses the new choice, not the stale one
  assign inSelNow = (wrStb && hit(regIdx, `AUXCV_IDX_CTRL)) ?
                    wb[`AUXCV_CTRL_INSEL_A] : inSelFirstPin;

  // Latch the input pin used by this conversion
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinFirst_r <= 1'b0;
    end else if ((chStart[0] || chAvg[0]) && !chBusy[0]) begin
      pinFirst_r <= inSelNow;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      resA1_r <= 10'h000;
      resA2_r <= 10'h000;
      resB_r <= 10'h000;
    end else begin
      if (chValid[0] && pinFirst_r) begin
        resA1_r <= chResult[0];
      end
      if (chValid[0] && !pinFirst_r) begin
        resA2_r <= chResult[0];
      end
      if (chValid[1]) begin
        resB_r <= chResult[1];
      end
    end
  end

  // Side port readback of the chosen converter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sidePortResult <= 10'h000;
    end else if (sidePortChoice) begin
      sidePortResult <= resB_r;
    end else begin
      sidePortResult <= pinFirst_r ? resA1_r : resA2_r;
    end
  end

  // ==========================================
  // Read path
  logic [7:0] rdByte;

  // Upper eight and lower two bits
  always_comb begin
    rdByte = 8'h00;
    if (alignedOk) begin
      unique case (regIdx)
        `AUXCV_IDX_RES_A1_HI: rdByte = resA1_r[9:2];
        `AUXCV_IDX_RES_A1_LO: rdByte = {6'h00, resA1_r[1:0]};
        `AUXCV_IDX_RES_A2_HI: rdByte = resA2_r[9:2];
        `AUXCV_IDX_RES_A2_LO: rdByte = {6'h00, resA2_r[1:0]};
        `AUXCV_IDX_RES_B_HI: rdByte = resB_r[9:2];
        `AUXCV_IDX_RES_B_LO: rdByte = {6'h00, resB_r[1:0]};
        `AUXCV_IDX_CTRL: rdByte = ctrl_r;
        `AUXCV_IDX_REFCFG: rdByte = {6'h00, refCfg_r};
        `AUXCV_IDX_AVG_A: rdByte = {5'h00, avgCodeA_r};
        `AUXCV_IDX_AVG_B: rdByte = {5'h00, avgCodeB_r};
        `AUXCV_IDX_CLKDIV: rdByte = {6'h00, clkDiv_r};
        default: rdByte = 8'h00;
      endcase
    end
  end

  // Read data registered with the acknowledge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rdStb) begin
      avs_readdata <= {24'h00_0000, rdByte};
    end
  end
endmodule
`default_nettype wire

// >>> verification/aux_converter_control_props.sv
// Purpose: Port-level timing checks for aux_converter_control.
// Assumes: One clock domain; bus requests start after internal reset.
// Notes: Bound to the top module, watches ports only.
`default_nettype none
module aux_converter_control_props (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic convTick,
  input wire logic sidePortEn,
  input wire logic sidePortChoice,
  input wire logic refSelA,
  input wire logic refSelB,
  input wire logic refIntEn,
  input wire logic refScale2v5,
  input wire logic inSelFirstPin,
  input wire logic sampleReqA,
  input wire logic busyA,
  input wire logic sampleReqB,
  input wire logic busyB
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ==========================================
  // Bus steps
  sequence s_rd_ans;
    avs_read && !avs_waitrequest;
  endsequence
  sequence s_wr_ans(logic [9:0] a);
    avs_write && !avs_waitrequest && avs_address == a && avs_byteenable[0];
  endsequence
  // One wait state, never a stall when idle
  chk_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  chk_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest while idle");
  chk_upper_zero: assert property (s_rd_ans |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  chk_spare_zero: assert property (
    s_rd_ans ##0 (avs_address == 10'h080 || avs_address == 10'h084)
    |-> avs_readdata == 32'h0000_0000)
    else $error("spare result not zero");
  chk_start_rdzero: assert property (
    s_rd_ans ##0 avs_address == 10'h088 |-> !avs_readdata[3] && !avs_readdata[0])
    else $error("start bit read as one");
  // Control fields follow the accepted write
  chk_ctrl_fields: assert property (
    s_wr_ans(10'h088) |=> sidePortEn == $past(avs_writedata[7])
    && sidePortChoice == $past(avs_writedata[6]) && refSelB == $past(avs_writedata[5])
    && refSelA == $past(avs_writedata[2]) && inSelFirstPin == $past(avs_writedata[1]))
    else $error("control field mismatch");
  chk_ref_fields: assert property (
    s_wr_ans(10'h05C) |=> refIntEn == $past(avs_writedata[1])
    && refScale2v5 == $past(avs_writedata[0]))
    else $error("reference field mismatch");
  chk_req_pulse: assert property (sampleReqA |=> !sampleReqA)
    else $error("sample request too long");
  chk_req_busy: assert property (!(sampleReqA && !busyA) && !(sampleReqB && !busyB))
    else $error("sample request while idle");
  chk_req_tick: assert property (sampleReqA || sampleReqB |-> $past(convTick))
    else $error("sample request without tick");
endmodule
bind aux_converter_control aux_converter_control_props i_aux_converter_control_props (
  .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .convTick(convTick),
  .sidePortEn(sidePortEn), .sidePortChoice(sidePortChoice), .refSelA(refSelA),
  .refSelB(refSelB), .refIntEn(refIntEn), .refScale2v5(refScale2v5),
  .inSelFirstPin(inSelFirstPin), .sampleReqA(sampleReqA), .busyA(busyA),
  .sampleReqB(sampleReqB), .busyB(busyB));
`default_nettype wire

// >>> verification/aux_converter_control_tb_top.sv
// Purpose: Self-checking bench for aux_converter_control.
// Assumes: Converters answer a sample request one cycle later.
// Notes: Sample data ramps by one per request, so each average is the lower middle sample.
`default_nettype none
module aux_converter_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, arst_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [9:0] avs_address = 0, sidePortResult, sampleDataA = 0, sampleDataB = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, q;
  logic [3:0] avs_byteenable = 0;
  logic rxClkTick = 1, serClkTick = 0, convTick, sidePortStart = 0, sidePortEn, sidePortChoice;
  logic refSelA, refSelB, refIntEn, refScale2v5, inSelFirstPin, busyA, busyB;
  logic sampleReqA, sampleDoneA = 0, sampleReqB, sampleDoneB = 0;
  logic [9:0] baseA = 10'h105, baseB = 10'h27B, m, lastA;
  int n_fail = 0, n_tests = 0, nA = 0, nB = 0, ticks = 0, serDiv = 0, n0, t0;
  aux_converter_control i_aux_converter_control (.core_clk(core_clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rxClkTick(rxClkTick), .serClkTick(serClkTick),
    .convTick(convTick), .sidePortStart(sidePortStart), .sidePortEn(sidePortEn),
    .sidePortChoice(sidePortChoice), .sidePortResult(sidePortResult), .refSelA(refSelA),
    .refSelB(refSelB), .refIntEn(refIntEn), .refScale2v5(refScale2v5),
    .inSelFirstPin(inSelFirstPin), .sampleReqA(sampleReqA), .sampleDoneA(sampleDoneA),
    .sampleDataA(sampleDataA), .busyA(busyA), .sampleReqB(sampleReqB),
    .sampleDoneB(sampleDoneB), .sampleDataB(sampleDataB), .busyB(busyB));
  // ==========================================
  // Clock, serial tick and converter stand-ins
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // Data inverts outside the done cycle so stale values cannot pass
  always @(posedge core_clk) begin
    // Receive enable every other cycle, so the dividers see real gaps
    rxClkTick <= ~rxClkTick;
    serDiv <= (serDiv == 4) ? 0 : serDiv + 1;
    serClkTick <= (serDiv == 4);
    sampleDoneA <= sampleReqA;
    sampleDataA <= sampleReqA ? baseA + 10'(nA) : ~sampleDataA;
    nA <= nA + int'(sampleReqA);
    sampleDoneB <= sampleReqB;
    sampleDataB <= sampleReqB ? baseB + 10'(nB) : ~sampleDataB;
    nB <= nB + int'(sampleReqB);
    ticks <= ticks + int'(convTick);
  end
  // ==========================================
  // Shared tasks
  task end_of_test;
    $display("n_tests=%0d n_fail=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Holds the request until waitrequest is seen low at an edge
  task bus(input logic wr, input logic [9:0] a, input logic [7:0] d, input logic [3:0] be);
    int i;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    q = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    if (avs_waitrequest !== 1'b0) begin
      n_fail++;
      end_of_test;
    end
  endtask
  task wr(input logic [9:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask
  task rd(input logic [9:0] a, input logic [7:0] ex, input string nm);
    bus(1'b0, a, 8'h00, 4'h0);
    chk(nm, {24'h0, ex}, q);
  endtask
  task rd_res(input logic [9:0] a, input logic [9:0] v);
    rd(a, v[9:2], "result high");
    rd(a + 10'h004, {6'h0, v[1:0]}, "result low");
  endtask
  task wait_done;
    int i;
    repeat (3) @(posedge core_clk);
    i = 0;
    while ((busyA | busyB) !== 1'b0 && i < 3000) begin
      @(posedge core_clk);
      i++;
    end
    if (i >= 3000) begin
      n_fail++;
      end_of_test;
    end
    @(posedge core_clk);
    // Registered outputs launched at that edge are settled by now
    @(negedge core_clk);
  endtask
  // ==========================================
  // Scenarios
  task t_reset;
    rd(10'h088, 8'h00, "control reset");
    rd(10'h08C, 8'h00, "clock code reset");
    rd(10'h090, 8'h00, "unmapped");
    rd(10'h089, 8'h00, "misaligned");
    bus(1'b1, 10'h088, 8'h80, 4'h0);
    rd(10'h088, 8'h00, "masked write");
    $display("t_reset done");
  endtask
  task t_ctrl;
    wr(10'h088, 8'hE6);
    @(negedge core_clk);
    chk("fields", 5'h1F, {sidePortEn, sidePortChoice, refSelB, refSelA, inSelFirstPin});
    rd(10'h088, 8'hE6, "control back");
    wr(10'h05C, 8'h02);
    @(negedge core_clk);
    chk("ref cfg", 2'h2, {refIntEn, refScale2v5});
    wr(10'h088, 8'h00);
    @(negedge core_clk);
    chk("fields off", 5'h00, {sidePortEn, sidePortChoice, refSelB, refSelA, inSelFirstPin});
    $display("t_ctrl done");
  endtask
  task t_avg;
    int n;
    wr(10'h08C, 8'h02);
    wr(10'h088, 8'h02);
    for (int c = 0; c < 8; c++) begin
      n0 = nA;
      n = (c == 7) ? 1 : 1 << c;
      wr(10'h060, 8'h80 | 8'(c));
      wait_done;
      m = 10'(baseA + n0 + (n - 1) / 2);
      chk("sample count", n, nA - n0);
      rd_res(10'h068, m);
    end
    $display("t_avg done");
  endtask
  task t_busy;
    n0 = nA;
    wr(10'h060, 8'h83);
    wr(10'h088, 8'h03);
    chk("busy", 1, busyA);
    rd_res(10'h068, m);
    wait_done;
    chk("count while busy", 8, nA - n0);
    m = 10'(baseA + n0 + 3);
    rd_res(10'h068, m);
    n0 = nA;
    wr(10'h088, 8'h01);
    wait_done;
    lastA = 10'(baseA + n0);
    rd_res(10'h070, lastA);
    rd_res(10'h068, m);
    $display("t_busy done");
  endtask
  task t_convB;
    n0 = nB;
    wr(10'h088, 8'h08);
    wait_done;
    rd_res(10'h078, 10'(baseB + n0));
    rd_res(10'h080, 10'h000);
    rd(10'h088, 8'h00, "start reads zero");
    $display("t_convB done");
  endtask
  task pulse_side;
    @(posedge core_clk);
    sidePortStart <= 1;
    @(posedge core_clk);
    sidePortStart <= 0;
  endtask
  task t_side;
    n0 = nB;
    wr(10'h088, 8'h40);
    pulse_side;
    repeat (20) @(posedge core_clk);
    chk("side disabled", n0, nB);
    wr(10'h088, 8'hC0);
    pulse_side;
    wait_done;
    chk("side start", n0 + 1, nB);
    chk("side result B", 10'(baseB + n0), sidePortResult);
    wr(10'h088, 8'h80);
    // Readback register follows the new choice one edge after the write
    @(posedge core_clk);
    @(negedge core_clk);
    chk("side result A", lastA, sidePortResult);
    n0 = nA;
    pulse_side;
    wait_done;
    chk("side start A", n0 + 1, nA);
    chk("side new A", 10'(baseA + n0), sidePortResult);
    $display("t_side done");
  endtask
  task t_clk;
    int ex[4] = '{5, 10, 20, 8};
    for (int c = 0; c < 4; c++) begin
      wr(10'h08C, 8'(c));
      repeat (8) @(posedge core_clk);
      t0 = ticks;
      repeat (40) @(posedge core_clk);
      chk("tick rate", ex[c], ticks - t0);
    end
    $display("t_clk done");
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    arst_n <= 1;
    repeat (3) @(posedge core_clk);
    t_reset;
    t_ctrl;
    t_avg;
    t_busy;
    t_convB;
    t_side;
    t_clk;
    end_of_test;
  end
endmodule
`default_nettype wire
